//--- hdl/bl_boot_loader.sv
/*
  Boot loader of one tile: reset delay, strap decode, byte sources (quad and single
  flash master, serial slave, one-time memory, channel), image parse, check, RAM load.
  Assumes RAM, one-time memory and channel logic on mclk; pins come from outside.
*/
`include "bl_defs.svh"
`default_nettype none
module bl_boot_loader #(
  parameter logic TILE = 1'b0,
  parameter int RAM_AW = 16,
  parameter int OTP_AW = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // straps and security
  input wire logic boot_strap_0,
  input wire logic boot_strap_1,
  input wire logic boot_strap_2,
  input wire logic [15:0] sec_reg,
  // pad control
  output logic gpio_pull_down,
  output logic link_zero_en,
  output logic link_zero_2w,
  // serial flash pins
  input wire logic spi_sclk_i,
  output logic spi_sclk_o,
  output logic spi_sclk_oe,
  input wire logic spi_ss_n_i,
  output logic spi_ss_n_o,
  output logic spi_ss_n_oe,
  input wire logic spi_mosi_i,
  output logic spi_mosi_o,
  output logic spi_mosi_oe,
  input wire logic spi_miso,
  input wire logic [3:0] spi_dq,
  // one-time memory read port
  output logic otp_rd,
  output logic [OTP_AW-1:0] otp_addr,
  input wire logic [7:0] otp_rdata,
  // channel end zero
  input wire logic chan_valid,
  input wire logic [7:0] chan_data,
  output logic chan_ready,
  input wire logic chan_eot,
  output logic ack_end,
  output logic [31:0] ack_chan,
  // RAM write port
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic ram_wready,
  // status
  output bl_pkg::bl_src_e boot_src,
  output logic boot_done,
  output logic boot_fail,
  output logic run_start
);
  import bl_pkg::*;

  bl_stream_if #(.W(8)) fi ();
  bl_stream_if #(.W(8)) fo ();

  bl_fifo #(.DEPTH(2), .W(8)) u_fifo (
    .clk(mclk),
    .rst_n(arst_n),
    .in_s(fi.snk),
    .out_s(fo.src)
  );

  // pin synchronisers: only the second stage is read
  logic [10:0] sync1, sync2;
  logic [2:0] strap_s;
  logic sclk_s, ss_s, mosi_s, miso_s;
  logic [3:0] dq_s;
  assign strap_s = sync2[2:0];
  assign sclk_s = sync2[3];
  assign ss_s = sync2[4];
  assign mosi_s = sync2[5];
  assign miso_s = sync2[6];
  assign dq_s = sync2[10:7];

  bl_state_e state, next_state;
  bl_src_e next_src;
  logic [`BL_DELAY_W-1:0] dly, next_dly;
  logic next_pd, next_link, next_drive, drive;
  logic src_valid, next_src_valid;
  logic [7:0] src_byte, next_src_byte, sh, next_sh;
  logic [2:0] nb, next_nb;
  logic [5:0] cmd_left, next_cmd_left;
  logic [31:0] cmd_sr, next_cmd_sr;
  logic [7:0] div, next_div;
  logic sclk, next_sclk, ss_n, next_ss_n, sclk_q;
  logic next_otp_rd, next_chan_ready, next_ack_end;
  logic [OTP_AW-1:0] next_otp_addr;
  logic [1:0] bcnt, next_bcnt;
  logic [31:0] word, next_word, len, next_len, wcnt, next_wcnt, crc, next_crc;
  logic [31:0] nw, next_ack_chan, next_ram_wdata;
  logic next_ram_we, next_done, next_fail, next_run;
  logic [RAM_AW-1:0] next_ram_addr;
  logic streaming, take, tick;
  logic [7:0] asm_byte;

  // one reflected check step per byte, low bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `BL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // strap decode per tile; undefined patterns leave the tile without a source unless the secure boot bit forces the one-time memory
  function automatic bl_src_e decode(input logic [2:0] p, input logic sec);
    bl_src_e s;
    s = BL_SRC_NONE;
    case (p)
      3'b000: s = TILE ? BL_SRC_CHAN : BL_SRC_QSPI_M;
      3'b001: s = TILE ? BL_SRC_CHAN : BL_SRC_SPI_M;
      3'b010: s = TILE ? BL_SRC_CHAN : BL_SRC_SPI_S;
      3'b011: s = BL_SRC_SPI_S;
      3'b100: s = BL_SRC_CHAN;
      default: s = BL_SRC_NONE;
    endcase
    if (sec) begin
      s = BL_SRC_OTP;
    end
    return s;
  endfunction

  assign streaming = (state == BL_ST_ACK) || (state == BL_ST_LEN) || (state == BL_ST_PROG) || (state == BL_ST_CRC);
  // parser stalls while a RAM word waits, which backs up through the buffer
  assign fo.ready = streaming && !(ram_we && !ram_wready);
  assign take = fo.valid && fo.ready;
  assign fi.valid = src_valid;
  assign fi.data = src_byte;
  assign tick = (div == 8'h00);
  assign nw = {fo.data, word[31:8]};
  assign asm_byte = (boot_src == BL_SRC_QSPI_M) ? {dq_s, sh[7:4]} : {miso_s, sh[7:1]};

  // next values of the whole sequencer, byte sources and parser
  always_comb begin
    next_state = state;
    next_src = boot_src;
    next_dly = dly;
    next_pd = gpio_pull_down;
    next_link = link_zero_en;
    next_drive = drive;
    next_src_valid = src_valid;
    next_src_byte = src_byte;
    next_sh = sh;
    next_nb = nb;
    next_cmd_left = cmd_left;
    next_cmd_sr = cmd_sr;
    next_div = div;
    next_sclk = sclk;
    next_ss_n = ss_n;
    next_otp_rd = 1'b0;
    next_otp_addr = otp_addr;
    next_ack_end = 1'b0;
    next_bcnt = bcnt;
    next_word = word;
    next_len = len;
    next_wcnt = wcnt;
    next_crc = crc;
    next_ack_chan = ack_chan;
    next_ram_we = ram_we;
    next_ram_addr = ram_addr;
    next_ram_wdata = ram_wdata;
    next_done = boot_done;
    next_fail = boot_fail;
    next_run = 1'b0;
    if (src_valid && fi.ready) begin
      next_src_valid = 1'b0;
    end
    if (ram_we && ram_wready) begin
      next_ram_we = 1'b0;
    end
    // byte sources
    case (boot_src)
      BL_SRC_QSPI_M, BL_SRC_SPI_M: begin
        next_drive = streaming;
        next_ss_n = !streaming;
        next_div = tick ? 8'(`BL_SPI_HALF - 1) : div - 8'h01;
        // serial clock halts while a byte waits for room: no byte is lost
        if (streaming && tick && !src_valid) begin
          next_sclk = !sclk;
          if (!sclk && cmd_left != 6'h00) begin
            next_cmd_left = cmd_left - 6'h01;
          end else if (!sclk) begin
            next_sh = asm_byte;
            next_nb = nb + 3'h1;
            if (nb == ((boot_src == BL_SRC_QSPI_M) ? 3'h1 : 3'h7)) begin
              next_nb = 3'h0;
              next_src_valid = 1'b1;
              next_src_byte = asm_byte;
            end
          end else if (cmd_left != 6'h00) begin
            next_cmd_sr = {cmd_sr[30:0], 1'b0};
          end
        end else if (!streaming) begin
          next_sclk = 1'b0;
        end
      end
      BL_SRC_SPI_S: begin
        // rising edge serves modes 0/0 and 1/1; a byte arriving on a full stage overwrites the waiting byte
        if (streaming && !ss_s && sclk_s && !sclk_q) begin
          next_sh = {mosi_s, sh[7:1]};
          next_nb = nb + 3'h1;
          if (nb == 3'h7) begin
            next_src_valid = 1'b1;
            next_src_byte = {mosi_s, sh[7:1]};
          end
        end
      end
      BL_SRC_OTP: begin
        if (otp_rd) begin
          next_src_valid = 1'b1;
          next_src_byte = otp_rdata;
          next_otp_addr = otp_addr + OTP_AW'(1);
        end else if (streaming && !src_valid) begin
          next_otp_rd = 1'b1;
        end
      end
      BL_SRC_CHAN: begin
        if (chan_valid && chan_ready) begin
          next_src_valid = 1'b1;
          next_src_byte = chan_data;
        end
      end
      default: begin
      end
    endcase
    next_chan_ready = (boot_src == BL_SRC_CHAN) && streaming && !next_src_valid;
    // sequencer and image parser
    case (state)
      BL_ST_WAIT: begin
        next_dly = dly + `BL_DELAY_W'(1);
        if (dly == `BL_DELAY_W'(`BL_BOOT_DELAY_CYC - 1)) begin
          next_pd = 1'b0;
          next_src = decode(strap_s, sec_reg[`BL_SEC_BOOT_BIT]);
          next_link = (strap_s == `BL_STRAP_LINK);
          if (next_src == BL_SRC_NONE) begin
            next_state = BL_ST_FAIL;
          end else if (next_src == BL_SRC_CHAN) begin
            next_state = BL_ST_ACK;
          end else begin
            next_state = BL_ST_LEN;
          end
        end
      end
      BL_ST_ACK, BL_ST_LEN, BL_ST_PROG, BL_ST_CRC: begin
        if (take) begin
          next_word = nw;
          next_bcnt = bcnt + 2'h1;
          if (state == BL_ST_LEN || state == BL_ST_PROG) begin
            next_crc = crc_byte(crc, fo.data);
          end
          if (bcnt == 2'h3) begin
            case (state)
              BL_ST_ACK: begin
                next_ack_chan = nw;
                next_state = BL_ST_LEN;
              end
              BL_ST_LEN: begin
                next_len = nw;
                next_wcnt = 32'h0;
                next_state = (nw == 32'h0) ? BL_ST_CRC : BL_ST_PROG;
              end
              BL_ST_PROG: begin
                next_ram_we = 1'b1;
                next_ram_addr = wcnt[RAM_AW-1:0];
                next_ram_wdata = nw;
                next_wcnt = wcnt + 32'h1;
                if (wcnt + 32'h1 == len) begin
                  next_state = BL_ST_CRC;
                end
              end
              default: begin
                if (nw == `BL_NO_CRC || nw == ~crc) begin
                  next_state = (boot_src == BL_SRC_CHAN) ? BL_ST_EOT : BL_ST_RUN;
                end else begin
                  next_state = BL_ST_FAIL;
                end
              end
            endcase
          end
        end
      end
      BL_ST_EOT: begin
        if (chan_eot) begin
          next_state = BL_ST_SEND;
        end
      end
      BL_ST_SEND: begin
        next_ack_end = 1'b1;
        next_state = BL_ST_RUN;
      end
      BL_ST_RUN: begin
        // start only after the last word has left for RAM
        if (!ram_we && !boot_done) begin
          next_done = 1'b1;
          next_run = 1'b1;
        end
      end
      BL_ST_FAIL: begin
        next_fail = 1'b1;
      end
      default: begin
        next_state = BL_ST_FAIL;
      end
    endcase
  end

  // registers; the reset pin holds everything and turns the pull-downs on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
      state <= BL_ST_WAIT;
      boot_src <= BL_SRC_NONE;
      dly <= '0;
      gpio_pull_down <= 1'b1;
      link_zero_en <= 1'b0;
      drive <= 1'b0;
      src_valid <= 1'b0;
      src_byte <= 8'h00;
      sh <= 8'h00;
      nb <= 3'h0;
      cmd_left <= `BL_SPI_CMD_BITS;
      cmd_sr <= `BL_SPI_CMD;
      div <= 8'h00;
      sclk <= 1'b0;
      ss_n <= 1'b1;
      sclk_q <= 1'b0;
      otp_rd <= 1'b0;
      otp_addr <= '0;
      chan_ready <= 1'b0;
      ack_end <= 1'b0;
      bcnt <= 2'h0;
      word <= 32'h0;
      len <= 32'h0;
      wcnt <= 32'h0;
      crc <= `BL_CRC_INIT;
      ack_chan <= 32'h0;
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= 32'h0;
      boot_done <= 1'b0;
      boot_fail <= 1'b0;
      run_start <= 1'b0;
    end else begin
      sync1 <= {spi_dq, spi_miso, spi_mosi_i, spi_ss_n_i, spi_sclk_i, boot_strap_2, boot_strap_1, boot_strap_0};
      sync2 <= sync1;
      state <= next_state;
      boot_src <= next_src;
      dly <= next_dly;
      gpio_pull_down <= next_pd;
      link_zero_en <= next_link;
      drive <= next_drive;
      src_valid <= next_src_valid;
      src_byte <= next_src_byte;
      sh <= next_sh;
      nb <= next_nb;
      cmd_left <= next_cmd_left;
      cmd_sr <= next_cmd_sr;
      div <= next_div;
      sclk <= next_sclk;
      ss_n <= next_ss_n;
      sclk_q <= sclk_s;
      otp_rd <= next_otp_rd;
      otp_addr <= next_otp_addr;
      chan_ready <= next_chan_ready;
      ack_end <= next_ack_end;
      bcnt <= next_bcnt;
      word <= next_word;
      len <= next_len;
      wcnt <= next_wcnt;
      crc <= next_crc;
      ack_chan <= next_ack_chan;
      ram_we <= next_ram_we;
      ram_addr <= next_ram_addr;
      ram_wdata <= next_ram_wdata;
      boot_done <= next_done;
      boot_fail <= next_fail;
      run_start <= next_run;
    end
  end

  // pin drivers straight from flops; link zero only ever runs two-wire here
  assign link_zero_2w = link_zero_en;
  assign spi_sclk_o = sclk;
  assign spi_ss_n_o = ss_n;
  assign spi_mosi_o = cmd_sr[31];
  assign spi_sclk_oe = drive;
  assign spi_ss_n_oe = drive;
  assign spi_mosi_oe = drive;
endmodule
`default_nettype wire

//--- hdl/bl_defs.svh
/*
  Constants of the boot loader: timing counts, image markers, check polynomial,
  strap and security bit positions. Assumes a 200 MHz tile clock.
*/
`ifndef BL_DEFS_SVH
`define BL_DEFS_SVH

// clock period and the shortest internal reset process
`define BL_CLK_PERIOD_NS 5
`define BL_BOOT_DELAY_US 15
`define BL_BOOT_DELAY_CYC ((`BL_BOOT_DELAY_US * 1000 + `BL_CLK_PERIOD_NS - 1) / `BL_CLK_PERIOD_NS)
`define BL_DELAY_W 12

// security register: secure boot bit
`define BL_SEC_BOOT_BIT 5

// image check
`define BL_CRC_POLY 32'hedb88320
`define BL_CRC_INIT 32'hffffffff
`define BL_NO_CRC 32'h0d15ab1e

// flash read: command byte, 24-bit address zero, half period of the serial clock
`define BL_SPI_CMD 32'h03000000
`define BL_SPI_CMD_BITS 6'd32
`define BL_SPI_HALF 4

// strap pattern that enables link zero
`define BL_STRAP_LINK 3'b100

`endif

//--- hdl/bl_fifo.sv
/*
  Small first-in first-out buffer for the boot byte stream, registered entries.
  Assumes one clock and an asynchronous active-low reset.
*/
`default_nettype none
module bl_fifo #(
  parameter int DEPTH = 2,
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side and draining side
  bl_stream_if.snk in_s,
  bl_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  // honest full and empty; ready drops when every entry holds a word
  assign in_s.ready = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // pointer and fill level, wrapping for any depth
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // one register per entry, loaded only when written
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else if (push && (wr_ptr == AW'(i))) begin
        mem[i] <= in_s.data;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/bl_pkg.sv
/*
  Types of the boot loader: boot source and sequencer state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package bl_pkg;
  typedef enum logic [2:0] {
    BL_SRC_QSPI_M = 3'b000,
    BL_SRC_SPI_M = 3'b001,
    BL_SRC_SPI_S = 3'b010,
    BL_SRC_CHAN = 3'b011,
    BL_SRC_OTP = 3'b100,
    BL_SRC_NONE = 3'b111
  } bl_src_e;

  typedef enum logic [3:0] {
    BL_ST_WAIT = 4'b0000,
    BL_ST_ACK = 4'b0001,
    BL_ST_LEN = 4'b0010,
    BL_ST_PROG = 4'b0011,
    BL_ST_CRC = 4'b0100,
    BL_ST_EOT = 4'b0101,
    BL_ST_SEND = 4'b0110,
    BL_ST_RUN = 4'b0111,
    BL_ST_FAIL = 4'b1000
  } bl_state_e;
endpackage
`default_nettype wire

//--- hdl/bl_stream_if.sv
/*
  Byte stream with valid and ready between the boot loader and its buffer.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface bl_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

//--- verif/bl_boot_loader_assertions.sv
/*
  Checker on the boot loader's top ports.
  Assumes one clock, mclk, and an asynchronous active-low reset.
*/
`default_nettype none
module bl_boot_loader_assertions #(
  parameter int RAM_AW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pads and sources
  input wire logic gpio_pull_down,
  input wire logic link_zero_en,
  input wire logic link_zero_2w,
  input wire logic spi_sclk_oe,
  input wire logic otp_rd,
  input wire logic chan_ready,
  input wire logic chan_eot,
  input wire logic ack_end,
  // ram and status
  input wire logic ram_we,
  input wire logic ram_wready,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire bl_pkg::bl_src_e boot_src,
  input wire logic boot_fail,
  input wire logic run_start
);
  import bl_pkg::*;
  // end token in, answer out, then the start pulse
  sequence s_eot_tail;
    ##[1:2] ack_end ##[1:3] run_start;
  endsequence
  // a write waits for ready without changing
  sequence s_hold;
    ram_we && $stable(ram_addr) && $stable(ram_wdata);
  endsequence
  // no disable here: these values must hold while reset is low
  chk_reset_pads: assert property (@(posedge mclk) !arst_n |-> gpio_pull_down && boot_src == BL_SRC_NONE)
    else $error("pads or source wrong in reset");
  chk_src_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    !gpio_pull_down && !$past(gpio_pull_down) |-> $stable(boot_src)) else $error("boot source moved");
  chk_link_mode: assert property (@(posedge mclk) disable iff (!arst_n)
    link_zero_en |-> link_zero_2w && !gpio_pull_down) else $error("link on without two-wire mode");
  chk_otp_src: assert property (@(posedge mclk) disable iff (!arst_n)
    otp_rd |-> boot_src == BL_SRC_OTP) else $error("one-time memory read outside secure boot");
  chk_chan_src: assert property (@(posedge mclk) disable iff (!arst_n)
    chan_ready |-> boot_src == BL_SRC_CHAN) else $error("channel taken outside channel boot");
  chk_spi_master: assert property (@(posedge mclk) disable iff (!arst_n)
    spi_sclk_oe |-> boot_src inside {BL_SRC_QSPI_M, BL_SRC_SPI_M}) else $error("serial clock driven as slave");
  chk_fail_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
    boot_fail |=> boot_fail && !run_start) else $error("failed boot started or cleared");
  chk_run_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    run_start |-> !boot_fail ##1 !run_start) else $error("start pulse wrong");
  chk_ram_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    ram_we && !ram_wready |=> s_hold) else $error("ram write dropped or changed");
  chk_eot_order: assert property (@(posedge mclk) disable iff (!arst_n)
    chan_eot |-> s_eot_tail) else $error("end token answer out of order");
endmodule
bind bl_boot_loader bl_boot_loader_assertions #(.RAM_AW(RAM_AW)) u_bl_boot_loader_assertions (
  .mclk(mclk), .arst_n(arst_n), .gpio_pull_down(gpio_pull_down), .link_zero_en(link_zero_en),
  .link_zero_2w(link_zero_2w), .spi_sclk_oe(spi_sclk_oe), .otp_rd(otp_rd), .chan_ready(chan_ready),
  .chan_eot(chan_eot), .ack_end(ack_end), .ram_we(ram_we), .ram_wready(ram_wready), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .boot_src(boot_src), .boot_fail(boot_fail), .run_start(run_start));
`default_nettype wire

//--- verif/bl_boot_loader_tb.sv
/*
  Testbench: strap decode, channel boot, secure boot good and bad, single and quad flash boot.
  Assumes the loader waits its reset time after every release.
*/
`include "bl_defs.svh"
`default_nettype none
module bl_boot_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bl_pkg::*;
  localparam logic [31:0] ACK_WORD = 32'h5a3c0102;
  logic mclk, arst_n, boot_strap_0, boot_strap_1, boot_strap_2, ram_wready, chan_on;
  logic [15:0] sec_reg;
  logic gpio_pull_down, link_zero_en, link_zero_2w, spi_sclk_o, spi_sclk_oe, spi_ss_n_o, spi_ss_n_oe;
  logic spi_mosi_o, spi_mosi_oe, otp_rd, chan_valid, chan_ready, chan_eot, ack_end, ram_we;
  logic boot_done, boot_fail, run_start;
  logic [11:0] otp_addr;
  logic [7:0] otp_rdata, chan_data;
  logic spi_miso;
  logic [3:0] spi_dq;
  logic [31:0] ack_chan, ram_wdata, crc, ack_val;
  logic [15:0] ram_addr;
  bl_src_e boot_src;
  logic [31:0] exp_w [0:15];
  int n_fail, cmp_count, wcnt, runs, acks, pn, d;
  bl_src_e exp_src [0:3] = '{BL_SRC_QSPI_M, BL_SRC_SPI_M, BL_SRC_SPI_S, BL_SRC_SPI_S};

  bl_boot_loader u_bl_boot_loader (.mclk, .arst_n, .boot_strap_0, .boot_strap_1, .boot_strap_2, .sec_reg,
    .gpio_pull_down, .link_zero_en, .link_zero_2w, .spi_sclk_i(1'b0), .spi_sclk_o, .spi_sclk_oe,
    .spi_ss_n_i(1'b1), .spi_ss_n_o, .spi_ss_n_oe, .spi_mosi_i(1'b0), .spi_mosi_o, .spi_mosi_oe,
    .spi_miso, .spi_dq, .otp_rd, .otp_addr, .otp_rdata, .chan_valid, .chan_data, .chan_ready,
    .chan_eot, .ack_end, .ack_chan, .ram_we, .ram_addr, .ram_wdata, .ram_wready, .boot_src, .boot_done,
    .boot_fail, .run_start);
  bl_chan_peer u_bl_chan_peer (.mclk, .arst_n, .chan_on, .chan_valid, .chan_data, .chan_ready, .chan_eot,
    .otp_rd, .otp_addr, .otp_rdata, .spi_sclk(spi_sclk_o), .spi_ss_n(spi_ss_n_o), .spi_mosi(spi_mosi_o),
    .spi_miso, .spi_dq);

  // clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ram stalls every other cycle
  always @(posedge mclk) begin
    #1 ram_wready = ~ram_wready;
  end
  // watch ram writes, start pulses and end token answers
  always @(posedge mclk) begin
    if (arst_n && ram_we && ram_wready) begin
      chk("ram_addr", wcnt, 32'(ram_addr));
      chk("ram_wdata", exp_w[wcnt], ram_wdata);
      wcnt++;
    end
    if (arst_n && run_start) runs++;
    if (arst_n && ack_end) begin
      acks++;
      ack_val = ack_chan;
    end
  end
  // a hang counts as a failure
  initial begin
    #300000;
    n_fail++;
    results();
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one word into the image, low byte first, optionally into the check
  task automatic put(input logic [31:0] w, input logic upd);
    for (int i = 0; i < 4; i++) begin
      u_bl_chan_peer.img[pn] = w[8*i +: 8];
      if (upd) begin
        crc ^= {24'h0, w[8*i +: 8]};
        for (int b = 0; b < 8; b++) crc = crc[0] ? (crc >> 1) ^ `BL_CRC_POLY : crc >> 1;
      end
      pn++;
    end
  endtask
  // mode 0 skip marker, 1 good check, 2 check left uninverted
  task automatic load_img(input int nw, input int mode, input logic chan);
    pn = 0;
    crc = `BL_CRC_INIT;
    if (chan) put(ACK_WORD, 1'b0);
    put(nw, 1'b1);
    for (int k = 0; k < nw; k++) begin
      exp_w[k] = 32'h8f3a1c00 + k * 32'h01050203;
      put(exp_w[k], 1'b1);
    end
    put(mode == 0 ? `BL_NO_CRC : mode == 1 ? ~crc : crc, 1'b0);
    u_bl_chan_peer.n_bytes = pn;
    chan_on = chan;
  endtask
  task automatic boot(input logic [2:0] st, input logic sec);
    @(posedge mclk);
    #1 arst_n = 1'b0;
    {boot_strap_2, boot_strap_1, boot_strap_0} = st;
    sec_reg = 16'h0000;
    sec_reg[`BL_SEC_BOOT_BIT] = sec;
    wcnt = 0;
    runs = 0;
    acks = 0;
    repeat (16) @(posedge mclk);
    chk("pull_down", 1, gpio_pull_down);
    #1 arst_n = 1'b1;
    d = 0;
    while (gpio_pull_down !== 1'b0 && d < 31000) begin
      @(posedge mclk);
      #1 d++;
    end
    chk("boot_delay", 1, 32'(d >= `BL_BOOT_DELAY_CYC && d <= 30000));
  endtask
  task automatic finish_boot(input int nw, input logic good);
    int t;
    t = 0;
    while (runs == 0 && boot_fail !== 1'b1 && t < 20000) begin
      @(posedge mclk);
      #1 t++;
    end
    repeat (4) @(posedge mclk);
    #1 chk("runs", 32'(good), runs);
    chk("boot_fail", 32'(!good), boot_fail);
    chk("boot_done", 32'(good), boot_done);
    chk("ram_words", nw, wcnt);
  endtask

  // main sequence
  initial begin
    arst_n = 1'b1;
    {boot_strap_2, boot_strap_1, boot_strap_0} = 3'b000;
    sec_reg = 16'h0000;
    chan_on = 1'b0;
    ram_wready = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    // fall once every process waits, so the asynchronous reset sees a real edge before the first clock
    #1 arst_n = 1'b0;
    for (int s = 0; s < 4; s++) begin
      load_img(1, 0, 1'b0);
      boot(3'(s), 1'b0);
      repeat (3) @(posedge mclk);
      #1 chk("boot_src", exp_src[s], boot_src);
      chk("link_en", 0, link_zero_en);
      if (s < 2) chk("ss_n", 0, spi_ss_n_o);
      chk("pin_oe", (s < 2) ? 3'b111 : 3'b000, {spi_ss_n_oe, spi_sclk_oe, spi_mosi_oe});
    end
    load_img(2, 0, 1'b1);
    boot(`BL_STRAP_LINK, 1'b0);
    chk("link_en", 1, link_zero_en);
    chk("link_2w", 1, link_zero_2w);
    chk("boot_src", BL_SRC_CHAN, boot_src);
    finish_boot(2, 1'b1);
    chk("acks", 1, acks);
    chk("ack_chan", ACK_WORD, ack_val);
    load_img(3, 1, 1'b0);
    boot(3'b001, 1'b1);
    chk("boot_src", BL_SRC_OTP, boot_src);
    finish_boot(3, 1'b1);
    load_img(1, 2, 1'b0);
    boot(3'b000, 1'b1);
    finish_boot(1, 1'b0);
    load_img(2, 1, 1'b0);
    boot(3'b001, 1'b0);
    finish_boot(2, 1'b1);
    chk("flash_cmd", `BL_SPI_CMD, u_bl_chan_peer.cmd);
    load_img(1, 1, 1'b0);
    boot(3'b000, 1'b0);
    finish_boot(1, 1'b1);
    results();
  end
endmodule
`default_nettype wire

//--- verif/bl_chan_peer.sv
/*
  Far side: channel peer, one-time memory and serial flash, all holding one image.
  Assumes the bench fills img and n_bytes before reset is released.
*/
`default_nettype none
module bl_chan_peer #(
  parameter int OTP_AW = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // channel end zero
  input wire logic chan_on,
  output logic chan_valid,
  output logic [7:0] chan_data,
  input wire logic chan_ready,
  output logic chan_eot,
  // one-time memory
  input wire logic otp_rd,
  input wire logic [OTP_AW-1:0] otp_addr,
  output logic [7:0] otp_rdata,
  // serial flash pins
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic [3:0] spi_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] img [0:63];
  int n_bytes;
  int idx;
  int gap;
  logic tk;
  logic rd;
  logic [OTP_AW-1:0] a;
  int rises;
  logic prev_sck;
  logic [31:0] cmd;
  // offer held until taken; idle lines toggle so stale data never matches
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idx = 0;
      gap = 0;
      chan_valid = 1'b0;
      chan_eot = 1'b0;
      chan_data = 8'h00;
      otp_rdata = 8'h00;
    end else begin
      tk = chan_valid && chan_ready;
      #1;
      // the loader latches otp_rdata at the edge closing its otp_rd cycle, so answer the fresh address
      rd = otp_rd;
      a = otp_addr;
      idx += int'(tk);
      // end token a few cycles after the last byte, as a link would
      if (chan_on && idx == n_bytes && gap <= 8) begin
        gap++;
      end
      chan_eot = (gap == 8);
      chan_valid = chan_on && idx < n_bytes;
      chan_data = chan_valid ? img[idx] : ~chan_data;
      otp_rdata = rd ? img[a] : ~otp_rdata;
    end
  end
  // flash: 32 command bits on rises, then one count feeds both bit (single) and nibble (quad) order
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rises = 0;
      prev_sck = 1'b0;
      cmd = 32'h0;
      spi_miso = 1'b0;
      spi_dq = 4'h0;
    end else begin
      if (!spi_ss_n && spi_sclk && !prev_sck) begin
        if (rises < 32) cmd = {cmd[30:0], spi_mosi};
        rises++;
      end else if (spi_ss_n) begin
        rises = 0;
      end
      prev_sck = spi_sclk;
      #1;
      spi_miso = (rises < 32) ? 1'b0 : img[(rises - 32) / 8][(rises - 32) % 8];
      spi_dq = (rises < 32) ? 4'h0 : img[(rises - 32) / 2][4 * ((rises - 32) % 2) +: 4];
    end
  end
endmodule
`default_nettype wire
